// ---- verilog/sfl_pkg.sv ----
// shared constants, types and opcode map of the serial flash link timing block
// assumes a 10 MHz core clock; all cycle counts but LAT_CYC derive from CLK_PERIOD_NS
package sfl_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int TMR_W         = 19;
   // sync plus dispatch latency, taken off the busy and sleep entry times, not the wake or resume times
   localparam int LAT_CYC       = 4;

   localparam int WP_RESP_US                 = 1;
   localparam int LOCK_FREEZE_US             = 200;
   localparam int ULTRA_ENTRY_US             = 3;
   localparam int DEEP_ENTRY_US              = 2;
   localparam int PAGE_BUFFER_MOVE_TIME_US   = 180;
   localparam int PAGE_COMPARE_US            = 180;
   localparam int ERASE_PROG_MS              = 35;
   localparam int OTP_PROG_US                = 500;
   localparam int DEEPEST_SLEEP_WAKE_TIME_US = 100;
   localparam int SLEEP_RESUME_TIME_US       = 35;

   // longest times round down
   localparam int WP_RESP_CYC      = WP_RESP_US * 1000 / CLK_PERIOD_NS;
   localparam int LOCK_CYC         = LOCK_FREEZE_US * 1000 / CLK_PERIOD_NS;
   localparam int ULTRA_ENTRY_CYC  = ULTRA_ENTRY_US * 1000 / CLK_PERIOD_NS;
   localparam int DEEP_ENTRY_CYC   = DEEP_ENTRY_US * 1000 / CLK_PERIOD_NS;
   localparam int MOVE_CYC         = PAGE_BUFFER_MOVE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int COMPARE_CYC      = PAGE_COMPARE_US * 1000 / CLK_PERIOD_NS;
   localparam int ERASE_PROG_CYC   = ERASE_PROG_MS * 1000000 / CLK_PERIOD_NS;
   localparam int OTP_PROG_CYC     = OTP_PROG_US * 1000 / CLK_PERIOD_NS;
   localparam int ULTRA_WAKE_CYC   = DEEPEST_SLEEP_WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int DEEP_RESUME_CYC  = SLEEP_RESUME_TIME_US * 1000 / CLK_PERIOD_NS;

   localparam logic [7:0] OP_LOCKDOWN     = 8'hC1;
   localparam logic [7:0] OP_PAGE_TO_BUF  = 8'hC2;
   localparam logic [7:0] OP_PAGE_COMPARE = 8'hC3;
   localparam logic [7:0] OP_ERASE_PROG   = 8'hC4;
   localparam logic [7:0] OP_OTP_PROG     = 8'hC5;
   localparam logic [7:0] OP_DEEP_SLEEP   = 8'hC6;
   localparam logic [7:0] OP_ULTRA_SLEEP  = 8'hC7;
   localparam logic [7:0] OP_RESUME       = 8'hC8;

   localparam logic [3:0] CMD_LAST_BIT = 4'h7;
   localparam logic [3:0] CMD_DONE     = 4'h8;

   typedef enum logic [2:0] {
      SFL_IDLE  = 3'h0,
      SFL_BUSY  = 3'h1,
      SFL_ENTER = 3'h3,
      SFL_SLEEP = 3'h2,
      SFL_WAKE  = 3'h6
   } sfl_state_e;

   typedef struct packed {
      logic       busy;
      logic       protect;
      logic       deep;
      logic       ultra;
      logic [3:0] rsvd;
   } sfl_status_s;

   localparam sfl_status_s STATUS_RST = 8'h00;
endpackage

// ---- verilog/sfl_op_timer.sv ----
// down counter timing one internal operation
// assumes load_in is a one-cycle pulse from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module sfl_op_timer #(
   parameter int W = 19
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] count_in,
   output logic              done_out,
   output logic              running_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   if (W < 2) begin : g_chk
      $error("timer width too small");
   end

   always_comb
   begin
      cnt_d = cnt_q;
      if (load_in)
      begin
         cnt_d = count_in;
      end
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign done_out    = (cnt_q == W'(1));
   assign running_out = (cnt_q != '0);
endmodule // sfl_op_timer

`default_nettype wire

// ---- verilog/sfl_link_timing.sv ----
// serial flash link: bit shifting on the link clock, operation timing on the core clock
// assumes the host keeps its own clock limits, spacing and wait times
// Behaviour
// - output bits launch on falling clock edges, input bits sampled on rising edges
// - write protect engages and releases within 1 us of its input changing
// - lockdown freeze completes within 200 us; host waits before next command
// - ultra-deep sleep reached within 3 us of select rising
// - deep sleep reached within 2 us of select rising
// - page move or compare finishes within 180 us
// - page erase and program finishes within 35 ms
// - security area program finishes within 500 us
// - plain timing: output valid within clock low phase up to 85 MHz
// - commands accepted with clock idling low or high at select fall
`timescale 1ns/100ps
`default_nettype none
module sfl_link_timing #(
   parameter int ERASE_PROG_CYCLES = sfl_pkg::ERASE_PROG_CYC,
   parameter int OTP_PROG_CYCLES   = sfl_pkg::OTP_PROG_CYC
) (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic sck_in,
   input  wire logic cs_n_in,
   input  wire logic si_in,
   input  wire logic wp_n_in,
   output logic      so_out,
   output logic      so_oe_n_out,
   output logic      busy_out,
   output logic      protect_out,
   output logic      deep_sleep_out,
   output logic      ultra_sleep_out
);
   localparam int W = sfl_pkg::TMR_W;

   if (ERASE_PROG_CYCLES <= sfl_pkg::LAT_CYC || ERASE_PROG_CYCLES >= 2 ** W ||
       OTP_PROG_CYCLES <= sfl_pkg::LAT_CYC || OTP_PROG_CYCLES >= 2 ** W) begin : g_chk
      $error("operation cycle count out of timer range");
   end

   // ---------------- link side, rising edge ----------------
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] cmd_q, cmd_d;
   logic       tgl_q, tgl_d;
   logic [7:0] st_s1_q, st_s2_q;
   sfl_pkg::sfl_status_s status_q, status_d;

   always_comb
   begin
      cnt_d = cnt_q;
      rx_d  = rx_q;
      cmd_d = cmd_q;
      tgl_d = tgl_q;
      if (cnt_q != sfl_pkg::CMD_DONE)
      begin
         rx_d  = {rx_q[6:0], si_in};
         cnt_d = cnt_q + 4'h1;
      end
      if (cnt_q == sfl_pkg::CMD_LAST_BIT)
      begin
         cmd_d = {rx_q[6:0], si_in};
         tgl_d = ~tgl_q;
      end
   end

   // frame state clears while select is high, so mode 0 and mode 3 start alike
   // idle level ignored
   always_ff @(posedge sck_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         cnt_q   <= 4'h0;
         rx_q    <= 8'h00;
         st_s1_q <= 8'h00;
         st_s2_q <= 8'h00;
      end
      else
      begin
         cnt_q   <= cnt_d;
         rx_q    <= rx_d;
         st_s1_q <= 8'(status_q);
         st_s2_q <= st_s1_q;
      end
   end

   // command byte must outlive the frame for the core to pick it up
   always_ff @(posedge sck_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cmd_q <= 8'h00;
         tgl_q <= 1'b0;
      end
      else
      begin
         cmd_q <= cmd_d;
         tgl_q <= tgl_d;
      end
   end

   // ---------------- link side, falling edge ----------------
   logic [7:0] tx_q, tx_d;
   logic       so_q, so_d;
   logic       oe_n_q, oe_n_d;
   logic       live_q, live_d;

   always_comb
   begin
      tx_d   = tx_q;
      so_d   = so_q;
      oe_n_d = oe_n_q;
      live_d = live_q;
      // launch on falling edge; status byte repeats
      if (cnt_q == sfl_pkg::CMD_DONE)
      begin
         if (!live_q)
         begin
            so_d   = st_s2_q[7];
            tx_d   = {st_s2_q[6:0], st_s2_q[7]};
            live_d = 1'b1;
            oe_n_d = 1'b0;
         end
         else
         begin
            so_d = tx_q[7];
            tx_d = {tx_q[6:0], tx_q[7]};
         end
      end
   end

   // bit is out half a period before the host samples it
   always_ff @(negedge sck_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         tx_q   <= 8'h00;
         so_q   <= 1'b0;
         oe_n_q <= 1'b1;
         live_q <= 1'b0;
      end
      else
      begin
         tx_q   <= tx_d;
         so_q   <= so_d;
         oe_n_q <= oe_n_d;
         live_q <= live_d;
      end
   end

   assign so_out      = so_q;
   assign so_oe_n_out = oe_n_q;

   // a select pulse far shorter than the core clock is caught by toggling on its edge
   logic wake_tgl_q;
   always_ff @(negedge cs_n_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wake_tgl_q <= 1'b0;
      end
      else
      begin
         wake_tgl_q <= ~wake_tgl_q;
      end
   end

   // ---------------- core side ----------------
   logic wp_s1_q, wp_s2_q, cs_s1_q, cs_s2_q, cs_prev_q;
   logic tg_s1_q, tg_s2_q, tg_prev_q, wk_s1_q, wk_s2_q, wk_prev_q;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         {wp_s1_q, wp_s2_q}              <= 2'h3;
         {cs_s1_q, cs_s2_q, cs_prev_q}   <= 3'h7;
         {tg_s1_q, tg_s2_q, tg_prev_q}   <= 3'h0;
         {wk_s1_q, wk_s2_q, wk_prev_q}   <= 3'h0;
      end
      else
      begin
         {wp_s1_q, wp_s2_q}              <= {wp_n_in, wp_s1_q};
         {cs_s1_q, cs_s2_q, cs_prev_q}   <= {cs_n_in, cs_s1_q, cs_s2_q};
         {tg_s1_q, tg_s2_q, tg_prev_q}   <= {tgl_q, tg_s1_q, tg_s2_q};
         {wk_s1_q, wk_s2_q, wk_prev_q}   <= {wake_tgl_q, wk_s1_q, wk_s2_q};
      end
   end

   logic       cs_rise, tgl_edge, wake_edge, go;
   logic [7:0] cmd_sel;
   assign cs_rise   = cs_s2_q & ~cs_prev_q;
   assign tgl_edge  = tg_s2_q ^ tg_prev_q;
   assign wake_edge = wk_s2_q ^ wk_prev_q;

   logic [7:0] cap_q, cap_d;
   logic       pend_q, pend_d;
   assign cmd_sel = tgl_edge ? cmd_q : cap_q;
   assign go      = cs_rise & (pend_q | tgl_edge);

   function automatic logic [W-1:0] busy_len(input logic [7:0] op);
      case (op)
         sfl_pkg::OP_LOCKDOWN:     busy_len = W'(sfl_pkg::LOCK_CYC - sfl_pkg::LAT_CYC);
         sfl_pkg::OP_PAGE_TO_BUF:  busy_len = W'(sfl_pkg::MOVE_CYC - sfl_pkg::LAT_CYC);
         sfl_pkg::OP_PAGE_COMPARE: busy_len = W'(sfl_pkg::COMPARE_CYC - sfl_pkg::LAT_CYC);
         sfl_pkg::OP_ERASE_PROG:   busy_len = W'(ERASE_PROG_CYCLES - sfl_pkg::LAT_CYC);
         sfl_pkg::OP_OTP_PROG:     busy_len = W'(OTP_PROG_CYCLES - sfl_pkg::LAT_CYC);
         default:                  busy_len = '0;
      endcase
   endfunction

   sfl_pkg::sfl_state_e  state_q, state_d;
   logic                 ultra_q, ultra_d;
   logic                 load;
   logic [W-1:0]         load_val;
   logic [W-1:0]         op_len_q, op_len_d;
   logic                 tmr_done;

   always_comb
   begin
      cap_d    = tgl_edge ? cmd_q : cap_q;
      pend_d   = cs_rise ? 1'b0 : (tgl_edge | pend_q);
      state_d  = state_q;
      ultra_d  = ultra_q;
      load     = 1'b0;
      load_val = '0;
      unique case (state_q)
         sfl_pkg::SFL_IDLE:
         begin
            if (go && cmd_sel == sfl_pkg::OP_ULTRA_SLEEP)
            begin
               load     = 1'b1;
               load_val = W'(sfl_pkg::ULTRA_ENTRY_CYC - sfl_pkg::LAT_CYC);
               ultra_d  = 1'b1;
               state_d  = sfl_pkg::SFL_ENTER;
            end
            else if (go && cmd_sel == sfl_pkg::OP_DEEP_SLEEP)
            begin
               load     = 1'b1;
               load_val = W'(sfl_pkg::DEEP_ENTRY_CYC - sfl_pkg::LAT_CYC);
               ultra_d  = 1'b0;
               state_d  = sfl_pkg::SFL_ENTER;
            end
            else if (go && busy_len(cmd_sel) != '0)
            begin
               load     = 1'b1;
               load_val = busy_len(cmd_sel);
               state_d  = sfl_pkg::SFL_BUSY;
            end
         end
         sfl_pkg::SFL_BUSY, sfl_pkg::SFL_WAKE:
         begin
            // commands while busy are dropped; host waits
            if (tmr_done)
            begin
               state_d = sfl_pkg::SFL_IDLE;
            end
         end
         sfl_pkg::SFL_ENTER:
         begin
            if (tmr_done)
            begin
               state_d = sfl_pkg::SFL_SLEEP;
            end
         end
         sfl_pkg::SFL_SLEEP:
         begin
            if (ultra_q ? wake_edge : (go && cmd_sel == sfl_pkg::OP_RESUME))
            begin
               load     = 1'b1;
               load_val = ultra_q ? W'(sfl_pkg::ULTRA_WAKE_CYC) : W'(sfl_pkg::DEEP_RESUME_CYC);
               state_d  = sfl_pkg::SFL_WAKE;
            end
         end
         default:
         begin
            state_d = sfl_pkg::SFL_IDLE;
         end
      endcase
      op_len_d         = load ? load_val : op_len_q;
      status_d         = sfl_pkg::STATUS_RST;
      status_d.busy    = (state_d != sfl_pkg::SFL_IDLE) && (state_d != sfl_pkg::SFL_SLEEP);
      // protect follows synchronised input, 3 cycles worst case
      status_d.protect = ~wp_s2_q;
      status_d.deep    = (state_d == sfl_pkg::SFL_SLEEP) && !ultra_d;
      status_d.ultra   = (state_d == sfl_pkg::SFL_SLEEP) && ultra_d;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         state_q  <= sfl_pkg::SFL_IDLE;
         status_q <= sfl_pkg::STATUS_RST;
         ultra_q  <= 1'b0;
         cap_q    <= 8'h00;
         pend_q   <= 1'b0;
         op_len_q <= '0;
      end
      else
      begin
         state_q  <= state_d;
         status_q <= status_d;
         ultra_q  <= ultra_d;
         cap_q    <= cap_d;
         pend_q   <= pend_d;
         op_len_q <= op_len_d;
      end
   end

   sfl_op_timer #(.W(W)) u_timer (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .load_in     (load),
      .count_in    (load_val),
      .done_out    (tmr_done),
      .running_out ()
   );

   assign busy_out        = status_q.busy;
   assign protect_out     = status_q.protect;
   assign deep_sleep_out  = status_q.deep;
   assign ultra_sleep_out = status_q.ultra;

   // ---------------- checks ----------------
   localparam int WP_MAX    = sfl_pkg::WP_RESP_CYC;
   localparam int ULTRA_MAX = sfl_pkg::ULTRA_ENTRY_CYC;
   localparam int DEEP_MAX  = sfl_pkg::DEEP_ENTRY_CYC;
   logic [W:0] busy_run_q;
   always_ff @(posedge clk_in)
   begin
      busy_run_q <= (reset_in || !busy_out) ? '0 : busy_run_q + (W+1)'(1);
   end

   a_wp_engage: assert property (@(posedge clk_in) disable iff (reset_in)
      $fell(wp_n_in) ##1 (!wp_n_in)[*3] |-> ##[0:WP_MAX] protect_out) else $error("protect late");
   a_wp_release: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(wp_n_in) ##1 wp_n_in[*3] |-> ##[0:WP_MAX] !protect_out) else $error("release late");
   a_busy_bound: assert property (@(posedge clk_in) disable iff (reset_in)
      busy_run_q <= {1'b0, op_len_q} + (W+1)'(1)) else $error("operation overran its time");
   a_ultra_entry: assert property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_IDLE && go && cmd_sel == sfl_pkg::OP_ULTRA_SLEEP
      |-> ##[1:ULTRA_MAX] ultra_sleep_out) else $error("ultra sleep late");
   a_deep_entry: assert property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_IDLE && go && cmd_sel == sfl_pkg::OP_DEEP_SLEEP
      |-> ##[1:DEEP_MAX] deep_sleep_out) else $error("deep sleep late");
   a_busy_drop: assert property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_BUSY && go && !tmr_done |=> $stable(op_len_q))
      else $error("command taken while busy");
   a_sample_rise: assert property (@(posedge sck_in) disable iff (cs_n_in)
      cnt_q != sfl_pkg::CMD_DONE |=> rx_q[0] == $past(si_in)) else $error("input not sampled");
   a_quiet_head: assert property (@(negedge sck_in) disable iff (cs_n_in)
      cnt_q != sfl_pkg::CMD_DONE |-> ##1 so_oe_n_out) else $error("output before command end");
   a_out_ready: assert property (@(posedge sck_in) disable iff (cs_n_in)
      live_q |-> !so_oe_n_out && so_out == tx_q[0]) else $error("output not valid at rise");

   c_lock_done: cover property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_BUSY && tmr_done);
   c_ultra_wake: cover property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_SLEEP && ultra_q && wake_edge);
   c_deep_resume: cover property (@(posedge clk_in) disable iff (reset_in)
      state_q == sfl_pkg::SFL_SLEEP && !ultra_q && go);
   c_status_read: cover property (@(negedge sck_in) disable iff (cs_n_in) live_q);
endmodule // sfl_link_timing

`default_nettype wire

// ---- testbench/sfl_host_model.sv ----
// host side of the serial link: frames one command byte and reads status back
// assumes the device samples on rising and launches on falling clock edges
`timescale 1ns/100ps
`default_nettype none
module sfl_host_model (
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      si_out,
   input  wire logic so_in,
   input  wire logic so_oe_n_in,
   output var int    errs_out
);
   // 48 ns period, below every read limit
   localparam int HALF = 24;

   // select idles high, also through hardware reset
   initial
   begin
      sck_out  = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
      errs_out = 0;
   end

   // launch on rising edges, eight periods a byte, msb first
   task automatic frame(input logic [7:0] op, input bit mode3, input int nbits,
                        output logic [7:0] st);
      logic a;
      st = 8'h00;
      // clock settles at its idle level before select falls, no stray edge
      sck_out  = mode3;
      #HALF;
      cs_n_out = 1'b0;
      si_out   = op[7];
      #HALF;
      if (mode3)
      begin
         sck_out = 1'b0;
         #HALF;
      end
      for (int i = 0; i < nbits + 8 * int'(nbits == 8); i++)
      begin
         sck_out = 1'b1;
         a = so_in;
         #2;
         // spent data line toggles so a stale bit is never read as good
         si_out = (i < 7) ? op[6 - i] : ~si_out;
         #(HALF - 2);
         if (i >= 8)
         begin
            // bit valid in low phase, captured at the next fall
            if (a !== so_in || so_oe_n_in !== 1'b0)
               errs_out++;
            st = {st[6:0], so_in};
         end
         sck_out = 1'b0;
         #HALF;
      end
      sck_out = mode3;
      #HALF;
      cs_n_out = 1'b1;
      si_out   = ~si_out;
      #HALF;
      if (so_oe_n_in !== 1'b1)
         errs_out++;
   endtask

   // select low 30 ns, no clock, wakes the deepest sleep
   task automatic wake_pulse();
      cs_n_out = 1'b0;
      #30;
      cs_n_out = 1'b1;
   endtask
endmodule // sfl_host_model
`default_nettype wire

// ---- testbench/sfl_link_timing_test.sv ----
// self-checking bench of the link timing block
// assumes the host model on the link and a 10 MHz core clock
`timescale 1ns/100ps
`default_nettype none
module sfl_link_timing_test;
   // short program counts keep the run brief
   localparam int EP  = 40;
   localparam int OTP = 20;
   // power-up wait before any program or erase, 3 ms of core clock
   localparam int PUW = 30000;

   logic       clk_in;
   logic       reset_in;
   logic       wp_n_in;
   logic       sck;
   logic       cs_n;
   logic       si;
   logic       so;
   logic       so_oe_n;
   logic       busy;
   logic       prot;
   logic       deep;
   logic       ultra;
   logic [7:0] st;
   int         model_errs;
   int         failures = 0;
   int         cmp_count = 0;

   sfl_link_timing #(.ERASE_PROG_CYCLES(EP), .OTP_PROG_CYCLES(OTP)) DUT (
      .clk_in          (clk_in),
      .reset_in        (reset_in),
      .sck_in          (sck),
      .cs_n_in         (cs_n),
      .si_in           (si),
      .wp_n_in         (wp_n_in),
      .so_out          (so),
      .so_oe_n_out     (so_oe_n),
      .busy_out        (busy),
      .protect_out     (prot),
      .deep_sleep_out  (deep),
      .ultra_sleep_out (ultra)
   );

   sfl_host_model host (
      .sck_out    (sck),
      .cs_n_out   (cs_n),
      .si_out     (si),
      .so_in      (so),
      .so_oe_n_in (so_oe_n),
      .errs_out   (model_errs)
   );

   initial
   begin
      clk_in = 1'b0;
      forever
         #50 clk_in = ~clk_in;
   end

   task automatic final_report();
      failures += model_errs;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   // status flags, bit 3 busy down to bit 0 ultra
   function automatic logic [3:0] flags();
      return {busy, prot, deep, ultra};
   endfunction

   // wait for one flag to reach v, giving up past the limit
   task automatic flag_within(input int limit, input int idx, input logic v, input string msg);
      int         n;
      logic [3:0] f;
      n = 0;
      f = flags();
      while (n < limit && f[idx] !== v)
      begin
         @(negedge clk_in);
         n++;
         f = flags();
      end
      check(f[idx] === v, msg);
   endtask

   // busy must show and clear again within the limit
   task automatic busy_span(input int limit, input string msg);
      int n;
      bit seen;
      n = 0;
      seen = 1'b0;
      while (n <= limit && !(seen && busy === 1'b0))
      begin
         @(negedge clk_in);
         seen |= (busy === 1'b1);
         n++;
      end
      check(seen && busy === 1'b0, msg);
   endtask

   task automatic t_protect();
      @(negedge clk_in);
      wp_n_in = 1'b0;
      flag_within(sfl_pkg::WP_RESP_CYC, 2, 1'b1, "protect late");
      repeat (4) @(negedge clk_in);
      host.frame(8'h00, 1'b0, 8, st);
      check(st === 8'h40, "status with protect");
      @(negedge clk_in);
      wp_n_in = 1'b1;
      flag_within(sfl_pkg::WP_RESP_CYC, 2, 1'b0, "release late");
   endtask

   task automatic t_ops();
      logic [7:0] ops [5];
      int lim [5];
      ops = '{sfl_pkg::OP_LOCKDOWN, sfl_pkg::OP_PAGE_TO_BUF, sfl_pkg::OP_PAGE_COMPARE,
              sfl_pkg::OP_ERASE_PROG, sfl_pkg::OP_OTP_PROG};
      lim = '{sfl_pkg::LOCK_CYC, sfl_pkg::MOVE_CYC, sfl_pkg::COMPARE_CYC, EP, OTP};
      for (int i = 0; i < 5; i++)
      begin
         host.frame(ops[i], i[0], 8, st);
         if (lim[i] > 100)
         begin
            repeat (6) @(negedge clk_in);
            host.frame(8'h00, 1'b0, 8, st);
            check(st === 8'h80, "busy not in status");
         end
         busy_span(lim[i], "operation overran");
         repeat (4) @(negedge clk_in);
      end
   endtask

   task automatic t_short();
      host.frame(sfl_pkg::OP_LOCKDOWN, 1'b0, 5, st);
      repeat (10) @(negedge clk_in);
      check(busy === 1'b0, "short frame acted on");
   endtask

   task automatic t_sleep();
      host.frame(sfl_pkg::OP_DEEP_SLEEP, 1'b0, 8, st);
      flag_within(sfl_pkg::DEEP_ENTRY_CYC, 1, 1'b1, "deep entry late");
      repeat (4) @(negedge clk_in);
      host.frame(sfl_pkg::OP_RESUME, 1'b1, 8, st);
      busy_span(sfl_pkg::DEEP_RESUME_CYC + 10, "resume too long");
      check(deep === 1'b0, "still in deep sleep");
   endtask

   task automatic t_ultra();
      host.frame(sfl_pkg::OP_ULTRA_SLEEP, 1'b1, 8, st);
      flag_within(sfl_pkg::ULTRA_ENTRY_CYC, 0, 1'b1, "ultra entry late");
      repeat (4) @(negedge clk_in);
      host.wake_pulse();
      busy_span(sfl_pkg::ULTRA_WAKE_CYC + 10, "wake too long");
      check(ultra === 1'b0, "still in ultra sleep");
   endtask

   // watchdog, about twice the expected run length
   initial
   begin
      #8000000;
      failures++;
      final_report();
   end

   initial
   begin
      reset_in = 1'b1;
      wp_n_in  = 1'b1;
      repeat (8) @(negedge clk_in);
      reset_in = 1'b0;
      repeat (2) @(negedge clk_in);
      check(flags() === 4'h0, "flags after reset");
      t_protect();
      repeat (PUW) @(negedge clk_in);
      t_ops();
      t_short();
      t_sleep();
      t_ultra();
      final_report();
   end
endmodule // sfl_link_timing_test
`default_nettype wire
